// file: axi_request_user_layer.sv
`timescale 1ns/1ps

// What this block does
// - without this layer the raw transaction request/response ports face the parent design
// - exactly one memory-mapped slave port serves all user traffic
// - requests sit in a transmit buffer the transaction layer drains when able
// - the transmit buffer always holds 512 entries of storage
// - a smaller configured depth is the fill level where throttling starts
// - write data width is 2, 4 or 8 flits of 128 bits
// - read data width is 2, 4 or 8 flits of 128 bits
// - transaction size never exceeds the largest request payload; master stays within it
// - aligned-write option: master aligns write addresses, alignment logic is skipped
// - aligned-read option: master aligns read addresses, alignment logic is skipped
// - with reordering, responses leave in the order their requests were issued
module axi_request_user_layer
  import axi_request_user_layer_pkg::*;
(
  input  wire logic                                            clk,
  input  wire logic                                            arst_n,
  input  wire logic [axi_request_user_layer_pkg::BUF_CNT_BITS-1:0] txDepth,
  input  wire logic                                            awvalid,
  output logic                                                 awready,
  input  wire logic [axi_request_user_layer_pkg::ID_BITS-1:0]      awid,
  input  wire logic [axi_request_user_layer_pkg::ADDR_BITS-1:0]    awaddr,
  input  wire logic                                            wvalid,
  output logic                                                 wready,
  input  wire logic [axi_request_user_layer_pkg::WR_BITS-1:0]      wdata,
  input  wire logic [axi_request_user_layer_pkg::STRB_BITS-1:0]    wstrb,
  output logic                                                 bvalid,
  input  wire logic                                            bready,
  output logic [axi_request_user_layer_pkg::ID_BITS-1:0]           bid,
  output logic [1:0]                                           bresp,
  input  wire logic                                            arvalid,
  output logic                                                 arready,
  input  wire logic [axi_request_user_layer_pkg::ID_BITS-1:0]      arid,
  input  wire logic [axi_request_user_layer_pkg::ADDR_BITS-1:0]    araddr,
  output logic                                                 rvalid,
  input  wire logic                                            rready,
  output logic [axi_request_user_layer_pkg::ID_BITS-1:0]           rid,
  output logic [axi_request_user_layer_pkg::RD_BITS-1:0]           rdata,
  output logic [1:0]                                           rresp,
  output logic                                                 rlast,
  output logic                                                 tlReqValid,
  output logic [axi_request_user_layer_pkg::REQ_BITS-1:0]          tlReqData,
  input  wire logic                                            tlReqReady,
  input  wire logic                                            tlRspValid,
  output logic                                                 tlRspReady,
  input  wire logic [axi_request_user_layer_pkg::TAG_BITS-1:0]     tlRspTag,
  input  wire logic [axi_request_user_layer_pkg::RD_BITS-1:0]      tlRspData,
  input  wire logic                                            tlRspError
);
  import axi_request_user_layer_pkg::*;

  // ************************************************************
  // reset release
  // ************************************************************
  logic rstMeta;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstMeta <= 1'b0;
      rst_n   <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rst_n   <= rstMeta;
    end
  end

  // ************************************************************
  // throttle level and tag availability
  // ************************************************************
  logic [BUF_CNT_BITS-1:0] fill;
  logic [BUF_CNT_BITS-1:0] limit;
  logic                    roomOk;
  logic [TAG_BITS-1:0]     issueTag;
  logic [TAG_BITS-1:0]     headTag;
  logic [TAGS-1:0]         busy;
  logic [TAGS-1:0]         filled;

  // zero or an oversize value means the full buffer
  assign limit  = (txDepth == '0 || txDepth > BUF_FULL_COUNT) ? BUF_FULL_COUNT : txDepth;
  assign roomOk = (fill < limit) && !busy[issueTag];

  // ************************************************************
  // slave port acceptance
  // ************************************************************
  typedef enum logic [2:0] {
    GRANT_IDLE  = 3'b001,
    GRANT_WRITE = 3'b010,
    GRANT_READ  = 3'b100
  } grant_t;

  grant_t grant;
  grant_t next_grant;
  logic   preferRead;
  logic   wrPending;
  logic   rdPending;
  logic   wrTake;
  logic   rdTake;

  assign wrPending = awvalid && wvalid;
  assign wrTake    = awvalid && awready && wvalid && wready;
  assign rdTake    = arvalid && arready;

  always_comb
  begin
    next_grant = GRANT_IDLE;
    case (grant)
      GRANT_IDLE:
      begin
        if (roomOk && rdPending && (preferRead || !wrPending))
          next_grant = GRANT_READ;
        else if (roomOk && wrPending)
          next_grant = GRANT_WRITE;
      end
      GRANT_WRITE: next_grant = GRANT_IDLE;
      GRANT_READ:  next_grant = GRANT_IDLE;
      default:     next_grant = GRANT_IDLE;
    endcase
  end

  assign rdPending = arvalid;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      grant      <= GRANT_IDLE;
      preferRead <= 1'b0;
      awready    <= 1'b0;
      wready     <= 1'b0;
      arready    <= 1'b0;
    end
    else
    begin
      grant   <= next_grant;
      awready <= (next_grant == GRANT_WRITE);
      wready  <= (next_grant == GRANT_WRITE);
      arready <= (next_grant == GRANT_READ);
      if (wrTake)
        preferRead <= 1'b1;
      else if (rdTake)
        preferRead <= 1'b0;
    end
  end

  // ************************************************************
  // request packing
  // ************************************************************
  logic                 pushValid;
  logic [REQ_BITS-1:0]  pushData;
  logic [ADDR_BITS-1:0] wrAddr;
  logic [ADDR_BITS-1:0] rdAddr;

  // alignment hardware exists only when the master is not bound to align
  assign wrAddr = WR_ADDR_ALIGNED ? awaddr : alignAddr(awaddr, WR_BITS / 8);
  assign rdAddr = RD_ADDR_ALIGNED ? araddr : alignAddr(araddr, RD_BITS / 8);

  assign pushValid = wrTake || rdTake;

  always_comb
  begin
    pushData = '0;
    pushData[REQ_WRITE_LSB]                       = wrTake;
    pushData[REQ_TAG_LSB +: TAG_BITS]             = issueTag;
    pushData[REQ_ADDR_LSB +: ADDR_BITS]           = wrTake ? wrAddr : rdAddr;
    if (wrTake)
    begin
      pushData[REQ_DATA_LSB +: WR_BITS]   = wdata;
      pushData[REQ_STRB_LSB +: STRB_BITS] = wstrb;
    end
  end

  // the request ports toward the transaction layer are the native interface
  tx_request_buffer u_buffer
  (
    .clk      (clk),
    .rst_n    (rst_n),
    .pushValid(pushValid),
    .pushData (pushData),
    .popValid (tlReqValid),
    .popData  (tlReqData),
    .popReady (tlReqReady),
    .fill     (fill)
  );

  // ************************************************************
  // response tracking
  // ************************************************************
  logic                 robWrite [TAGS];
  logic [ID_BITS-1:0]   robId    [TAGS];
  logic [RD_BITS-1:0]   robData  [TAGS];
  logic                 robErr   [TAGS];
  logic [TAG_BITS-1:0]  sel;
  logic                 selHit;
  logic                 bFree;
  logic                 rFree;
  logic                 deliver;

  assign bFree = !bvalid || bready;
  assign rFree = !rvalid || rready;

  // in order mode only the oldest tag may leave, otherwise the lowest-numbered arrived one
  always_comb
  begin
    sel = headTag;
    if (!REORDER_EN)
    begin
      for (int i = TAGS - 1; i >= 0; i--)
        if (filled[i])
          sel = TAG_BITS'(i);
    end
  end

  assign selHit  = filled[sel] && busy[sel];
  assign deliver = selHit && (robWrite[sel] ? bFree : rFree);

  always_ff @(posedge clk)
  begin
    if (pushValid)
    begin
      robWrite[issueTag] <= wrTake;
      robId[issueTag]    <= wrTake ? awid : arid;
    end
    if (tlRspValid)
    begin
      robData[tlRspTag] <= tlRspData;
      robErr[tlRspTag]  <= tlRspError;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy       <= '0;
      filled     <= '0;
      issueTag   <= '0;
      headTag    <= '0;
      tlRspReady <= 1'b0;
    end
    else
    begin
      tlRspReady <= 1'b1;
      if (pushValid)
        issueTag <= issueTag + 1'b1;
      if (deliver && REORDER_EN)
        headTag <= headTag + 1'b1;
      for (int i = 0; i < TAGS; i++)
      begin
        if (pushValid && issueTag == TAG_BITS'(i))
          busy[i] <= 1'b1;
        else if (deliver && sel == TAG_BITS'(i))
          busy[i] <= 1'b0;
        // a response landing in a slot always wins over the slot's release
        if (tlRspValid && tlRspTag == TAG_BITS'(i))
          filled[i] <= 1'b1;
        else if (deliver && sel == TAG_BITS'(i))
          filled[i] <= 1'b0;
      end
    end
  end

  // ************************************************************
  // response channels
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalid <= 1'b0;
      bid    <= '0;
      bresp  <= RESP_OKAY;
      rvalid <= 1'b0;
      rid    <= '0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
      rlast  <= 1'b0;
    end
    else
    begin
      if (deliver && robWrite[sel])
      begin
        bvalid <= 1'b1;
        bid    <= robId[sel];
        bresp  <= robErr[sel] ? RESP_SLVERR : RESP_OKAY;
      end
      else if (bready)
        bvalid <= 1'b0;
      if (deliver && !robWrite[sel])
      begin
        rvalid <= 1'b1;
        rid    <= robId[sel];
        rdata  <= robData[sel];
        rresp  <= robErr[sel] ? RESP_SLVERR : RESP_OKAY;
        rlast  <= 1'b1;
      end
      else if (rready)
      begin
        rvalid <= 1'b0;
        rlast  <= 1'b0;
      end
    end
  end

endmodule // axi_request_user_layer

// file: axi_request_user_layer_pkg.sv
package axi_request_user_layer_pkg;

  // ************************************************************
  // channel geometry
  // ************************************************************
  localparam int FLIT_BITS    = 128;
  localparam int WR_FLITS_CFG = 2;
  localparam int RD_FLITS_CFG = 2;
  localparam int ADDR_BITS    = 34;
  localparam int ID_BITS      = 4;
  localparam int STRB_SCALE   = 8;

  // largest request payload in flits; transactions are one beat of the channel
  localparam int MAX_PAYLOAD_FLITS = 8;
  localparam int MAX_WR_FLITS      = WR_FLITS_CFG;
  localparam int MAX_RD_FLITS      = RD_FLITS_CFG;

  // ************************************************************
  // options
  // ************************************************************
  localparam bit WR_ADDR_ALIGNED = 1'b0;
  localparam bit RD_ADDR_ALIGNED = 1'b0;
  localparam bit REORDER_EN      = 1'b1;

  // ************************************************************
  // transmit buffer and response tracking
  // ************************************************************
  localparam int BUF_ENTRIES  = 512;
  localparam int BUF_PTR_BITS = 9;
  localparam int BUF_CNT_BITS = 10;
  localparam int TAG_BITS     = 3;
  localparam int TAGS         = 8;

  localparam logic [BUF_CNT_BITS-1:0] BUF_FULL_COUNT = 10'h200;
  localparam logic [1:0]              RESP_OKAY      = 2'h0;
  localparam logic [1:0]              RESP_SLVERR    = 2'h2;

  // ************************************************************
  // functions
  // ************************************************************
  function automatic bit legalFlits(input int flits);
    return (flits == 2) || (flits == 4) || (flits == 8);
  endfunction

  function automatic int pickFlits(input int flits, input int maxFlits);
    int f;
    f = legalFlits(flits) ? flits : 2;
    return (f > maxFlits) ? maxFlits : f;
  endfunction

  localparam int WR_FLITS = pickFlits(WR_FLITS_CFG, MAX_PAYLOAD_FLITS);
  localparam int RD_FLITS = pickFlits(RD_FLITS_CFG, MAX_PAYLOAD_FLITS);
  localparam int WR_BITS  = WR_FLITS * FLIT_BITS;
  localparam int RD_BITS  = RD_FLITS * FLIT_BITS;
  localparam int STRB_BITS = WR_BITS / STRB_SCALE;

  // request entry layout: write flag, tag, address, data, strobes
  localparam int REQ_WRITE_LSB = 0;
  localparam int REQ_TAG_LSB   = 1;
  localparam int REQ_ADDR_LSB  = REQ_TAG_LSB + TAG_BITS;
  localparam int REQ_DATA_LSB  = REQ_ADDR_LSB + ADDR_BITS;
  localparam int REQ_STRB_LSB  = REQ_DATA_LSB + WR_BITS;
  localparam int REQ_BITS      = REQ_STRB_LSB + STRB_BITS;

  function automatic logic [ADDR_BITS-1:0] alignAddr(input logic [ADDR_BITS-1:0] addr, input int bytes);
    logic [ADDR_BITS-1:0] mask;
    mask = ADDR_BITS'(bytes - 1);
    return addr & ~mask;
  endfunction

endpackage

// file: axi_request_user_layer_properties.sv
`timescale 1ns/1ps

module axi_request_user_layer_properties
  import axi_request_user_layer_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    arst_n,
  input wire logic                    awvalid,
  input wire logic                    awready,
  input wire logic                    wvalid,
  input wire logic                    wready,
  input wire logic                    arvalid,
  input wire logic                    arready,
  input wire logic                    bvalid,
  input wire logic                    bready,
  input wire logic [ID_BITS-1:0]      bid,
  input wire logic                    rvalid,
  input wire logic                    rready,
  input wire logic [RD_BITS-1:0]      rdata,
  input wire logic                    rlast,
  input wire logic                    tlReqValid,
  input wire logic                    tlReqReady,
  input wire logic [REQ_BITS-1:0]     tlReqData,
  input wire logic                    tlRspValid,
  input wire logic                    tlRspReady
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_b_wait;
    bvalid && !bready;
  endsequence
  sequence s_r_wait;
    rvalid && !rready;
  endsequence

  a_wr_grant: assert property (awready |-> $past(awvalid && wvalid) && wready)
    else $error("write granted without both valids");
  a_rd_grant: assert property (arready |-> $past(arvalid))
    else $error("read granted without valid");
  a_aw_pulse: assert property (awready |=> !awready && !arready)
    else $error("grant after write too soon");
  a_ar_pulse: assert property (arready |=> !arready && !awready)
    else $error("grant after read too soon");
  a_req_hold: assert property (tlReqValid && !tlReqReady |=> tlReqValid && $stable(tlReqData))
    else $error("request dropped before taken");
  a_b_hold: assert property (s_b_wait |=> bvalid && $stable(bid))
    else $error("write response not held");
  a_r_hold: assert property (s_r_wait |=> rvalid && $stable(rdata))
    else $error("read response not held");
  a_r_single: assert property (rvalid |-> rlast)
    else $error("read beat without last");
  a_rsp_taken: assert property (tlRspValid |-> tlRspReady)
    else $error("response offered while not ready");
endmodule // axi_request_user_layer_properties

bind axi_request_user_layer axi_request_user_layer_properties prop_u (.clk, .arst_n, .awvalid, .awready,
  .wvalid, .wready, .arvalid, .arready, .bvalid, .bready, .bid, .rvalid, .rready, .rdata, .rlast,
  .tlReqValid, .tlReqReady, .tlReqData, .tlRspValid, .tlRspReady);

// file: axi_request_user_layer_tb.sv
`timescale 1ns/1ps

module axi_request_user_layer_tb;
  import axi_request_user_layer_pkg::*;
  logic clk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, rlast, tlReqValid, tlReqReady, tlRspValid, tlRspReady, tlRspError;
  logic stall, answer, reverse;
  logic [BUF_CNT_BITS-1:0] txDepth;
  logic [ID_BITS-1:0]      awid, bid, arid, rid;
  logic [ADDR_BITS-1:0]    awaddr, araddr;
  logic [WR_BITS-1:0]      wdata;
  logic [STRB_BITS-1:0]    wstrb;
  logic [1:0]              bresp, rresp;
  logic [RD_BITS-1:0]      rdata, tlRspData;
  logic [REQ_BITS-1:0]     tlReqData, lastReq;
  logic [TAG_BITS-1:0]     tlRspTag, nextTag;
  int err_count = 0;
  int check_count = 0;

  axi_request_user_layer dut_u (.clk, .arst_n, .txDepth, .awvalid, .awready, .awid, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bid, .bresp, .arvalid, .arready, .arid, .araddr, .rvalid,
    .rready, .rid, .rdata, .rresp, .rlast, .tlReqValid, .tlReqData, .tlReqReady, .tlRspValid, .tlRspReady,
    .tlRspTag, .tlRspData, .tlRspError);
  tl_partner partner_u (.clk, .arst_n, .stall, .answer, .reverse, .tlReqValid, .tlReqData, .tlReqReady,
    .tlRspValid, .tlRspTag, .tlRspData, .tlRspError, .lastReq);

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input bit ok, input string msg);
    check_count++;
    if (!ok)
    begin
      err_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic do_read(input logic [ID_BITS-1:0] id, input logic [ADDR_BITS-1:0] a);
    int n;
    arvalid <= 1'b1;
    arid    <= id;
    araddr  <= a;
    n = 0;
    do begin @(posedge clk); n++; end while (arready !== 1'b1 && n < 1000);
    arvalid <= 1'b0;
    check(n < 1000, "read not granted");
    nextTag++;
    @(posedge clk);
  endtask

  task automatic get_read(input logic [ID_BITS-1:0] id, input logic [TAG_BITS-1:0] tag);
    int n;
    rready <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (rvalid !== 1'b1 && n < 1000);
    check(rvalid === 1'b1 && rid === id && rdata === {RD_BITS/8{5'h00, tag}}
          && rresp === ((tag == 3'h6) ? RESP_SLVERR : RESP_OKAY), "read answer wrong");
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic test_write();
    int n;
    logic [ADDR_BITS-1:0] a;
    a = 34'h1_2345_678F;
    @(posedge clk);
    awvalid <= 1'b1;
    awid    <= 4'h5;
    bready  <= 1'b0;
    awaddr  <= a;
    wdata   <= {16{16'hA5C3}};
    wstrb   <= 32'hF0F0_00FF;
    n = 0;
    repeat (6) @(posedge clk) n += (awready === 1'b1);
    check(n == 0, "address taken without data");
    wvalid <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (awready !== 1'b1 && n < 1000);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    check(wready === 1'b1, "data not taken with address");
    n = 0;
    do begin @(posedge clk); n++; end while (bvalid !== 1'b1 && n < 1000);
    repeat (3) @(posedge clk);
    check(bvalid === 1'b1 && bid === 4'h5, "write answer not held");
    bready <= 1'b1;
    @(posedge clk);
    check(bvalid === 1'b1 && bid === 4'h5 && bresp === RESP_OKAY, "write answer wrong");
    check(lastReq[REQ_WRITE_LSB] === 1'b1 && lastReq[REQ_TAG_LSB +: TAG_BITS] === nextTag, "write head");
    check(lastReq[REQ_ADDR_LSB +: ADDR_BITS] === (a & ~34'h1F), "write address");
    check(lastReq[REQ_DATA_LSB +: WR_BITS] === {16{16'hA5C3}}, "write data");
    check(lastReq[REQ_STRB_LSB +: STRB_BITS] === 32'hF0F0_00FF, "write strobes");
    nextTag++;
    @(posedge clk);
  endtask

  task automatic test_reorder();
    logic [TAG_BITS-1:0] t;
    t = nextTag;
    answer  <= 1'b0;
    reverse <= 1'b1;
    do_read(4'h1, 34'h0_0000_0040);
    repeat (2) @(posedge clk);
    check(lastReq[REQ_WRITE_LSB] === 1'b0, "read flagged write");
    check(lastReq[REQ_ADDR_LSB +: ADDR_BITS] === 34'h0_0000_0040, "read address");
    do_read(4'h2, 34'h0_0000_0085);
    repeat (2) @(posedge clk);
    check(lastReq[REQ_ADDR_LSB +: ADDR_BITS] === 34'h0_0000_0080, "read address not aligned");
    do_read(4'h3, 34'h0_0000_00C0);
    answer <= 1'b1;
    repeat (12) @(posedge clk);
    get_read(4'h1, t);
    get_read(4'h2, t + 3'h1);
    get_read(4'h3, t + 3'h2);
  endtask

  task automatic test_throttle();
    int n;
    logic [TAG_BITS-1:0] t;
    t = nextTag;
    txDepth <= 10'h002;
    stall   <= 1'b1;
    answer  <= 1'b0;
    reverse <= 1'b0;
    do_read(4'h7, 34'h0_0000_0100);
    do_read(4'h8, 34'h0_0000_0120);
    arvalid <= 1'b1;
    arid    <= 4'h9;
    araddr  <= 34'h0_0000_0140;
    n = 0;
    repeat (20) @(posedge clk) n += (arready === 1'b1);
    check(n == 0, "taken above fill limit");
    stall <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (arready !== 1'b1 && n < 100);
    arvalid <= 1'b0;
    check(n < 100, "not resumed after drain");
    nextTag++;
    answer <= 1'b1;
    get_read(4'h7, t);
    get_read(4'h8, t + 3'h1);
    get_read(4'h9, t + 3'h2);
    txDepth <= 10'h000;
  endtask

  initial
  begin
    arst_n = 1'b0;
    {awvalid, wvalid, arvalid, rready, stall, reverse} = '0;
    bready = 1'b1;
    answer = 1'b1;
    txDepth = 10'h000;
    {awid, arid, awaddr, araddr, wdata, wstrb} = '0;
    nextTag = '0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    test_write();
    test_reorder();
    test_throttle();
    repeat (5) @(posedge clk);
    give_verdict();
  end

  initial
  begin
    #200000;
    err_count++;
    give_verdict();
  end
endmodule // axi_request_user_layer_tb

// file: tl_partner.sv
`timescale 1ns/1ps

module tl_partner
  import axi_request_user_layer_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                stall,
  input  wire logic                answer,
  input  wire logic                reverse,
  input  wire logic                tlReqValid,
  input  wire logic [REQ_BITS-1:0] tlReqData,
  output logic                     tlReqReady,
  output logic                     tlRspValid,
  output logic [TAG_BITS-1:0]      tlRspTag,
  output logic [RD_BITS-1:0]       tlRspData,
  output logic                     tlRspError,
  output logic [REQ_BITS-1:0]      lastReq
);
  logic [TAG_BITS-1:0] tags[$];

  // drains whenever not stalled
  assign tlReqReady = !stall;

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tags.delete();
      tlRspValid <= 1'b0;
      tlRspTag   <= '0;
      tlRspData  <= '0;
      tlRspError <= 1'b0;
      lastReq    <= '0;
    end
    else
    begin
      if (tlReqValid && tlReqReady)
      begin
        tags.push_back(tlReqData[REQ_TAG_LSB +: TAG_BITS]);
        lastReq <= tlReqData;
      end
      // idle lines toggle so stale values never look valid
      tlRspValid <= 1'b0;
      tlRspTag   <= ~tlRspTag;
      tlRspData  <= ~tlRspData;
      tlRspError <= 1'b0;
      if (answer && tags.size() > 0)
      begin
        tlRspValid <= 1'b1;
        tlRspTag   <= reverse ? tags[$] : tags[0];
        tlRspData  <= {RD_BITS/8{5'h00, (reverse ? tags[$] : tags[0])}};
        // tag 6 answers with an error so the error path is exercised
        tlRspError <= ((reverse ? tags[$] : tags[0]) == 3'h6);
        if (reverse)
          void'(tags.pop_back());
        else
          void'(tags.pop_front());
      end
    end
  end
endmodule // tl_partner

// file: tx_request_buffer.sv
`timescale 1ns/1ps

module tx_request_buffer
  import axi_request_user_layer_pkg::*;
(
  input  wire logic                                              clk,
  input  wire logic                                              rst_n,
  input  wire logic                                              pushValid,
  input  wire logic [axi_request_user_layer_pkg::REQ_BITS-1:0]     pushData,
  output logic                                                   popValid,
  output logic [axi_request_user_layer_pkg::REQ_BITS-1:0]          popData,
  input  wire logic                                              popReady,
  output logic [axi_request_user_layer_pkg::BUF_CNT_BITS-1:0]      fill
);

  // storage is always the full size, whatever threshold is in use
  logic [REQ_BITS-1:0]     mem [BUF_ENTRIES];
  logic [BUF_PTR_BITS-1:0] wrPtr;
  logic [BUF_PTR_BITS-1:0] rdPtr;
  logic [BUF_CNT_BITS-1:0] memCount;
  logic                    load;
  logic                    pushOk;

  assign pushOk = pushValid && (memCount != BUF_FULL_COUNT);
  assign load   = (memCount != '0) && (!popValid || popReady);

  always_ff @(posedge clk)
  begin
    if (pushOk)
      mem[wrPtr] <= pushData;
    if (load)
      popData <= mem[rdPtr];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr    <= '0;
      rdPtr    <= '0;
      memCount <= '0;
      popValid <= 1'b0;
    end
    else
    begin
      if (pushOk)
        wrPtr <= wrPtr + 1'b1;
      if (load)
        rdPtr <= rdPtr + 1'b1;
      memCount <= memCount + BUF_CNT_BITS'(pushOk) - BUF_CNT_BITS'(load);
      if (load)
        popValid <= 1'b1;
      else if (popReady)
        popValid <= 1'b0;
    end
  end

  assign fill = memCount + BUF_CNT_BITS'(popValid);

endmodule // tx_request_buffer
